// ===== common/pad_mux_pkg.sv
/*
  Constants and carrier types for the external bus / GPIO pad multiplexer.
  Assumes a 32-bit APB register bus and one pad group of eight shared pins.
*/
`default_nettype none
package pad_mux_pkg;
  localparam int unsigned NPIN = 8;
  localparam int unsigned PF_W = 7;
  localparam int unsigned PF_LSB = 9;
  localparam int unsigned PB_BIT = 0;
  localparam int unsigned DRV_BIT = 0;
  localparam int unsigned STAT_ACTIVE_BIT = 16;
  localparam int unsigned STAT_STRAP_BIT = 17;
  localparam logic [7:0] OFS_BUS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PB_PER = 8'h04;
  localparam logic [7:0] OFS_PB_DDR = 8'h08;
  localparam logic [7:0] OFS_PB_DR = 8'h0C;
  localparam logic [7:0] OFS_PB_PUR = 8'h10;
  localparam logic [7:0] OFS_PF_PER = 8'h14;
  localparam logic [7:0] OFS_PF_DDR = 8'h18;
  localparam logic [7:0] OFS_PF_DR = 8'h1C;
  localparam logic [7:0] OFS_PF_PUR = 8'h20;
  localparam logic [7:0] OFS_PIN_STATUS = 8'h24;
  localparam logic [6:0] RST_PF_PER = 7'h7F;
  localparam logic [7:0] RST_PIN_ZERO = 8'h00;
  localparam logic [7:0] RST_PIN_ONES = 8'hFF;
  localparam logic RST_DRV = 1'b0;

  typedef logic [NPIN-1:0] pin_t;
  typedef enum logic {ST_STRAP, ST_RUN} phase_e;

  // Pin index 0 is port B pin 0, indices 1 to 7 are port F pins 9 to 15.
  typedef struct packed {
    pin_t dout;
    pin_t oe_n;
    pin_t pull_en;
  } pad_ctl_s;

  typedef struct packed {
    logic active;
    logic addr16;
    logic data_oe;
    logic [PF_W-1:0] data_out;
  } ext_bus_s;
endpackage : pad_mux_pkg
`default_nettype wire

// ===== hw/ext_bus_gpio_pad_mux.sv
/*
  Pad multiplexer for port B pin 0 / address bit 16 and port F pins 9-15 / data lines 0-6,
  with its APB register file.
  Assumes the bus timing engine supplies the ext_bus_s signals and that pad inputs are
  synchronous to CLOCK.
*/
// The address map and the APB register port were decided locally.
// Notes on behaviour
// - With its function bit clear, port B pin 0 is a GPIO whose direction software sets.
// - With its function bit set, port B pin 0 carries address bit 16 of external accesses.
// - Address bit 16 floats on an idle bus unless the bus idle drive bit is set.
// - After reset port B pin 0 starts as GPIO or address from boot, mode and security straps.
// - A write to the port B function register overrides the startup choice.
// - Setting bit 0 of the port B pull-up register turns the pull-up of pin 0 off.
// - In bus mode port F pins 9-15 carry data lines 0-6 of external transfers.
// - The data lines float on an idle bus unless the bus idle drive bit is set.
// - Each port F pin 9-15 has its own direction bit as a GPIO.
// - Reset gives port F pins 9-15 to the data bus function.
// - Setting bit n of the port F pull-up register turns the pull-up of pin n off.
`timescale 1ns/10ps
`default_nettype none
module ext_bus_gpio_pad_mux (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output var logic PREADY,
  output var logic [31:0] PRDATA,
  output var logic PSLVERR,
  input wire pad_mux_pkg::ext_bus_s EXT_BUS,
  output var logic [pad_mux_pkg::PF_W-1:0] EXT_DATA_IN,
  input wire logic EXTERNAL_BOOT_STRAP,
  input wire logic BUS_MODE_STRAP,
  input wire logic FLASH_SECURE,
  input wire pad_mux_pkg::pin_t PAD_IN,
  output var pad_mux_pkg::pad_ctl_s PAD_CTL
);
  import pad_mux_pkg::*;

  typedef struct packed {
    phase_e phase;
    logic strap_addr;
    logic drv;
    pin_t per;
    pin_t ddr;
    pin_t dr;
    pin_t pur;
    pad_ctl_s pad;
    logic [PF_W-1:0] data_in;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

  state_s s_q;
  state_s s_d;
  pin_t bus_val;
  pin_t bus_out;
  pin_t nxt_dout;
  pin_t nxt_oe_n;
  logic access;
  logic wr;
  logic strap_fn;
  logic addr_mapped;

  assign access = PSEL && PENABLE;
  assign wr = access && s_q.pready && PWRITE;
  // Address bit 16 is wanted whenever booting externally, or in bus mode on an open part.
  assign strap_fn = EXTERNAL_BOOT_STRAP || (BUS_MODE_STRAP && !FLASH_SECURE);
  // Offsets outside the map answer with an error and leave every register alone.
  assign addr_mapped = PADDR inside {OFS_BUS_CTRL, OFS_PB_PER, OFS_PB_DDR, OFS_PB_DR,
    OFS_PB_PUR, OFS_PF_PER, OFS_PF_DDR, OFS_PF_DR, OFS_PF_PUR, OFS_PIN_STATUS};

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);

  assign bus_val[0] = EXT_BUS.addr16;
  assign bus_out[0] = 1'b1;
  assign bus_val[NPIN-1:1] = EXT_BUS.data_out;
  assign bus_out[NPIN-1:1] = {PF_W{EXT_BUS.data_oe}};

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    always_comb begin
      if (s_q.per[i]) begin
        nxt_dout[i] = bus_val[i];
        // Idle lines are driven with the current EXT_BUS values only when told to.
        nxt_oe_n[i] = EXT_BUS.active ? !bus_out[i] : !s_q.drv;
      end else begin
        nxt_dout[i] = s_q.dr[i];
        nxt_oe_n[i] = !s_q.ddr[i];
      end
    end
    chk_pin_gpio_path: assert property (
      !s_q.per[i] |=> PAD_CTL.oe_n[i] == !$past(s_q.ddr[i]) &&
        PAD_CTL.dout[i] == $past(s_q.dr[i]))
      else $error("A GPIO pin does not follow its direction and data bits.");
    chk_pin_idle_level: assert property (
      s_q.per[i] && !EXT_BUS.active |=> PAD_CTL.oe_n[i] == !$past(s_q.drv))
      else $error("An idle bus pin is not floated or held as the drive bit selects.");
    chk_pin_pull_level: assert property (
      1'b1 |=> PAD_CTL.pull_en[i] == !$past(s_q.pur[i]))
      else $error("A pin pull-up does not follow its control bit.");
  end

  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;
    s_d.pad.dout = nxt_dout;
    s_d.pad.oe_n = nxt_oe_n;
    s_d.pad.pull_en = ~s_q.pur;
    s_d.data_in = PAD_IN[NPIN-1:1];
    // One wait state lets the read data and the answer come from flip-flops.
    if (access && !s_q.pready) begin
      s_d.pready = 1'b1;
      unique case (PADDR)
        OFS_BUS_CTRL: s_d.prdata[DRV_BIT] = s_q.drv;
        OFS_PB_PER: s_d.prdata[PB_BIT] = s_q.per[0];
        OFS_PB_DDR: s_d.prdata[PB_BIT] = s_q.ddr[0];
        OFS_PB_DR: s_d.prdata[PB_BIT] = s_q.dr[0];
        OFS_PB_PUR: s_d.prdata[PB_BIT] = s_q.pur[0];
        OFS_PF_PER: s_d.prdata[PF_LSB +: PF_W] = s_q.per[NPIN-1:1];
        OFS_PF_DDR: s_d.prdata[PF_LSB +: PF_W] = s_q.ddr[NPIN-1:1];
        OFS_PF_DR: s_d.prdata[PF_LSB +: PF_W] = s_q.dr[NPIN-1:1];
        OFS_PF_PUR: s_d.prdata[PF_LSB +: PF_W] = s_q.pur[NPIN-1:1];
        OFS_PIN_STATUS: begin
          s_d.prdata[PB_BIT] = PAD_IN[0];
          s_d.prdata[PF_LSB +: PF_W] = PAD_IN[NPIN-1:1];
          s_d.prdata[STAT_ACTIVE_BIT] = EXT_BUS.active;
          s_d.prdata[STAT_STRAP_BIT] = s_q.strap_addr;
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (s_q.phase == ST_STRAP) begin
      s_d.phase = ST_RUN;
      s_d.strap_addr = strap_fn;
      s_d.per[0] = strap_fn;
    end
    if (wr) begin
      unique case (PADDR)
        OFS_BUS_CTRL: s_d.drv = PWDATA[DRV_BIT];
        OFS_PB_PER: s_d.per[0] = PWDATA[PB_BIT];
        OFS_PB_DDR: s_d.ddr[0] = PWDATA[PB_BIT];
        OFS_PB_DR: s_d.dr[0] = PWDATA[PB_BIT];
        OFS_PB_PUR: s_d.pur[0] = PWDATA[PB_BIT];
        OFS_PF_PER: s_d.per[NPIN-1:1] = PWDATA[PF_LSB +: PF_W];
        OFS_PF_DDR: s_d.ddr[NPIN-1:1] = PWDATA[PF_LSB +: PF_W];
        OFS_PF_DR: s_d.dr[NPIN-1:1] = PWDATA[PF_LSB +: PF_W];
        OFS_PF_PUR: s_d.pur[NPIN-1:1] = PWDATA[PF_LSB +: PF_W];
        default: s_d.phase = s_d.phase;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      s_q.phase <= ST_STRAP;
      s_q.strap_addr <= 1'b0;
      s_q.drv <= RST_DRV;
      s_q.per <= {RST_PF_PER, 1'b0};
      s_q.ddr <= RST_PIN_ZERO;
      s_q.dr <= RST_PIN_ZERO;
      s_q.pur <= RST_PIN_ZERO;
      s_q.pad.dout <= RST_PIN_ZERO;
      s_q.pad.oe_n <= RST_PIN_ONES;
      s_q.pad.pull_en <= RST_PIN_ONES;
      s_q.data_in <= RST_PF_PER ^ RST_PF_PER;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign PREADY = s_q.pready;
  assign PRDATA = s_q.prdata;
  assign PSLVERR = s_q.pslverr;
  assign PAD_CTL = s_q.pad;
  assign EXT_DATA_IN = s_q.data_in;

  sequence s_wr_to(logic [7:0] ofs);
    PSEL && PENABLE && PWRITE && PREADY && PADDR == ofs;
  endsequence

  sequence s_bus_idle_undriven(int unsigned k);
    s_q.per[k] && !EXT_BUS.active && !s_q.drv;
  endsequence

  chk_gp_pin_drive: assert property (
    !s_q.per[0] |=> PAD_CTL.oe_n[0] == !$past(s_q.ddr[0]) && PAD_CTL.dout[0] == $past(s_q.dr[0]))
    else $error("GPIO pin B0 does not follow its direction and data bits.");

  chk_addr_bus_drive: assert property (
    s_q.per[0] && EXT_BUS.active |=> !PAD_CTL.oe_n[0] && PAD_CTL.dout[0] == $past(EXT_BUS.addr16))
    else $error("Address bit 16 not driven during a bus access.");

  chk_addr_idle_float: assert property (
    s_bus_idle_undriven(0) |=> PAD_CTL.oe_n[0])
    else $error("Address bit 16 driven on an idle bus with drive bit clear.");

  chk_idle_drive_on: assert property (
    s_q.per[0] && !EXT_BUS.active && s_q.drv |=> !PAD_CTL.oe_n[0])
    else $error("Address bit 16 not held on an idle bus with drive bit set.");

  chk_strap_select: assert property (
    s_q.phase == ST_STRAP |=> s_q.phase == ST_RUN &&
      s_q.per[0] == $past(EXTERNAL_BOOT_STRAP || (BUS_MODE_STRAP && !FLASH_SECURE)))
    else $error("Startup function of pin B0 does not match the straps.");

  chk_per_override: assert property (
    s_wr_to(OFS_PB_PER) |=> s_q.per[0] == $past(PWDATA[PB_BIT]) ##1 PAD_CTL.oe_n[0] ==
      ($past(s_q.per[0]) ? ($past(EXT_BUS.active) ? 1'b0 : !$past(s_q.drv)) :
      !$past(s_q.ddr[0])))
    else $error("Write to the port B function register did not take over.");

  chk_pb_pull_off: assert property (
    s_wr_to(OFS_PB_PUR) |=> ##1 PAD_CTL.pull_en[0] == !$past(PWDATA[PB_BIT], 2))
    else $error("Port B pull-up does not follow its control bit.");

  chk_data_bus_write: assert property (
    &s_q.per[NPIN-1:1] && EXT_BUS.active && EXT_BUS.data_oe |=>
      PAD_CTL.oe_n[NPIN-1:1] == '0 && PAD_CTL.dout[NPIN-1:1] == $past(EXT_BUS.data_out))
    else $error("Data lines not driven with bus data during a write.");

  chk_data_idle_float: assert property (
    s_bus_idle_undriven(1) |=> PAD_CTL.oe_n[1])
    else $error("Data line 0 driven on an idle bus with drive bit clear.");

  chk_pf_dir_each: assert property (
    s_wr_to(OFS_PF_DDR) |=> s_q.ddr[NPIN-1:1] == $past(PWDATA[PF_LSB +: PF_W]))
    else $error("Port F direction bits not stored one per pin.");

  chk_pf_reset_bus: assert property (
    s_q.phase == ST_STRAP |-> s_q.per[NPIN-1:1] == RST_PF_PER)
    else $error("Port F pins not in data bus function after reset.");

  chk_pf_pull_off: assert property (
    s_wr_to(OFS_PF_PUR) |=> ##1 PAD_CTL.pull_en[NPIN-1:1] == ~$past(PWDATA[PF_LSB +: PF_W], 2))
    else $error("Port F pull-ups do not follow their control bits.");

  chk_gp_ignores_bus: assert property (
    !s_q.per[1] && $stable(s_q.dr[1]) && $stable(s_q.ddr[1]) |=>
      PAD_CTL.dout[1] == $past(s_q.dr[1]) && PAD_CTL.oe_n[1] == !$past(s_q.ddr[1]))
    else $error("Bus signals reached a GPIO pin.");

  chk_apb_one_wait: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("APB answer not given after exactly one wait state.");

  chk_read_lines_float: assert property (
    &s_q.per[NPIN-1:1] && EXT_BUS.active && !EXT_BUS.data_oe |=> &PAD_CTL.oe_n[NPIN-1:1])
    else $error("Data lines driven while the external memory answers a read.");

  chk_data_in_sample: assert property (
    1'b1 |=> EXT_DATA_IN == $past(PAD_IN[NPIN-1:1]))
    else $error("Read data from the data lines not passed on.");

  chk_drv_write: assert property (
    s_wr_to(OFS_BUS_CTRL) |=> s_q.drv == $past(PWDATA[DRV_BIT]))
    else $error("Bus idle drive bit not stored by its write.");

  chk_pb_dir_write: assert property (
    s_wr_to(OFS_PB_DDR) |=> s_q.ddr[0] == $past(PWDATA[PB_BIT]))
    else $error("Port B direction bit not stored by its write.");

  chk_pf_data_write: assert property (
    s_wr_to(OFS_PF_DR) |=> s_q.dr[NPIN-1:1] == $past(PWDATA[PF_LSB +: PF_W]))
    else $error("Port F data bits not stored by their write.");

  chk_pf_func_write: assert property (
    s_wr_to(OFS_PF_PER) |=> s_q.per[NPIN-1:1] == $past(PWDATA[PF_LSB +: PF_W]))
    else $error("Port F function bits not stored by their write.");

  chk_status_read: assert property (
    PSEL && PENABLE && !PREADY && PADDR == OFS_PIN_STATUS |=>
      PRDATA[STAT_STRAP_BIT] == $past(s_q.strap_addr) &&
      PRDATA[STAT_ACTIVE_BIT] == $past(EXT_BUS.active))
    else $error("Status read does not show the strap choice and bus activity.");

  chk_unmapped_error: assert property (
    PSEL && PENABLE && !PREADY && !addr_mapped |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("Access to an unmapped offset not answered with an error.");

  chk_mapped_no_error: assert property (
    PSEL && PENABLE && !PREADY && addr_mapped |=> PREADY && !PSLVERR)
    else $error("Access to a mapped offset answered with an error.");

  chk_unmapped_quiet: assert property (
    PSEL && PENABLE && PWRITE && PREADY && !addr_mapped |=>
      $stable(s_q.drv) && $stable(s_q.per) && $stable(s_q.ddr) && $stable(s_q.dr) &&
      $stable(s_q.pur))
    else $error("Write to an unmapped offset changed a register.");

  chk_ready_pulse: assert property (
    PREADY |=> !PREADY)
    else $error("APB answer held for more than one cycle.");

  chk_rdata_idle: assert property (
    !PREADY |-> PRDATA == 32'h0000_0000 && !PSLVERR)
    else $error("Read data or error shown outside the answer cycle.");
endmodule : ext_bus_gpio_pad_mux
`default_nettype wire

// ===== sim/ext_mem_model.sv
/*
  Behavioural external memory on the shared data lines; it also resolves every pad level.
  Assumes the bench plays the bus timing engine and supplies the read data.
*/
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
  input wire logic clk,
  input wire pad_mux_pkg::pad_ctl_s ctl,
  input wire pad_mux_pkg::ext_bus_s bus,
  input wire logic [6:0] rd_data,
  output var pad_mux_pkg::pin_t pad
);
  import pad_mux_pkg::*;
  pin_t last_q;
  // A released line without pull-up shows the inverse of its last level outside a bus read, so stale data fails.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (!ctl.oe_n[i]) pad[i] = ctl.dout[i];
      else if (i > 0 && bus.active && !bus.data_oe) pad[i] = rd_data[i-1];
      else if (ctl.pull_en[i]) pad[i] = 1'b1;
      else pad[i] = ~last_q[i];
    end
  end
  always_ff @(posedge clk) last_q <= pad;
endmodule : ext_mem_model
`default_nettype wire

// ===== sim/tb.sv
/*
  Self-checking bench for the pad multiplexer: register rows, bus and GPIO pads, straps.
  Assumes the memory model resolves the pad levels.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pad_mux_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_s;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, boot, mode, sec, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0] ext_in, rd;
  ext_bus_s bus;
  pin_t pad_in;
  pad_ctl_s ctl;
  int bad_count, tests_run, cyc;
  logic [3:0] straps [3] = '{4'b0110, 4'b0101, 4'b0000};
  row_s rows [8] = '{
    '{OFS_BUS_CTRL, 32'h1, 32'h1, 1'b0},
    '{OFS_PB_DDR, 32'hFFFFFFFF, 32'h1, 1'b0},
    '{OFS_PF_DDR, 32'hFFFF5555, 32'h5400, 1'b0},
    '{OFS_PB_DR, 32'h0, 32'h0, 1'b0},
    '{OFS_PF_DR, 32'hFFFFFE00, 32'hFE00, 1'b0},
    '{OFS_PB_PUR, 32'h1, 32'h1, 1'b0},
    '{OFS_PF_PUR, 32'h200, 32'h200, 1'b0},
    '{8'h30, 32'h1, 32'h0, 1'b1}};
  ext_bus_gpio_pad_mux i_dut (.CLOCK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .EXT_BUS(bus), .EXT_DATA_IN(ext_in), .EXTERNAL_BOOT_STRAP(boot),
    .BUS_MODE_STRAP(mode), .FLASH_SECURE(sec), .PAD_IN(pad_in), .PAD_CTL(ctl));
  ext_mem_model i_mem (.clk(clk), .ctl(ctl), .bus(bus), .rd_data(rd), .pad(pad_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task complete_run;
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task rst(input logic [2:0] s);
    {boot, mode, sec} <= s;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst
  task step(input ext_bus_s b);
    bus <= b;
    repeat (2) @(posedge clk);
  endtask : step
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    bus = '0;
    rd = 7'h2A;
    rst(3'b100);
    chk("idle oe_n", ctl.oe_n, 8'hFF);
    chk("pull_en", ctl.pull_en, 8'hFF);
    apb(1'b0, OFS_PB_PER, '0);
    chk("pb_per", r, 32'h1);
    apb(1'b0, OFS_PF_PER, '0);
    chk("pf_per", r, 32'hFE00);
    step('{1'b1, 1'b1, 1'b0, 7'h00});
    chk("rd oe_n", ctl.oe_n, 8'hFE);
    chk("rd dout0", ctl.dout[0], 1'b1);
    chk("data_in", ext_in, 7'h2A);
    step('{1'b1, 1'b0, 1'b1, 7'h55});
    chk("wr oe_n", ctl.oe_n, 8'h00);
    chk("wr dout", ctl.dout, 8'hAA);
    step('0);
    chk("idle oe_n", ctl.oe_n, 8'hFF);
    // The first row sets the idle drive bit, as software is expected to do.
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk("wr err", e, rows[i].e);
      apb(1'b0, rows[i].a, '0);
      chk("rd data", r, rows[i].x);
      chk("rd err", e, rows[i].e);
    end
    step('0);
    chk("drv oe_n", ctl.oe_n, 8'h00);
    chk("pull_en", ctl.pull_en, 8'hFC);
    apb(1'b1, OFS_PB_PER, '0);
    apb(1'b1, OFS_PF_PER, '0);
    step('{1'b1, 1'b1, 1'b1, 7'h7F});
    chk("gp oe_n", ctl.oe_n, 8'hAA);
    chk("gp dout", ctl.dout, 8'hFE);
    bus <= '0;
    foreach (straps[i]) begin
      rst(straps[i][3:1]);
      apb(1'b0, OFS_PIN_STATUS, '0);
      chk("strap", r[STAT_STRAP_BIT], straps[i][0]);
      chk("status", r, {14'h0000, straps[i][0], 1'b0, 7'h7F, 8'h00, 1'b1});
      apb(1'b0, OFS_PB_PER, '0);
      chk("pb_per", r, {31'h0, straps[i][0]});
    end
    complete_run();
  end
endmodule : tb
`default_nettype wire
